/* File: core/serial_tx_regs.vh */
// Register offsets, field positions, reset values and timing counts of the serial transmit port.
`ifndef SERIAL_TX_REGS_VH
`define SERIAL_TX_REGS_VH
`define ADDR_PIN0_SEL 8'h00
`define ADDR_PIN2_SEL 8'h04
`define ADDR_PKT_CTRL0 8'h08
`define ADDR_MODEM_CFG2 8'h0C
`define ADDR_MODEM_CFG3 8'h10
`define ADDR_RATE 8'h14
`define ADDR_SYNC_WORD 8'h18
`define ADDR_COMMAND 8'h1C
`define ADDR_STATUS 8'h20
`define SEL_INV_BIT 6
`define CMD_TX_BIT 0
`define CMD_IDLE_BIT 1
`define MANCHESTER_BIT 3
`define RST_PIN0_SEL 7'h3F
`define RST_PIN2_SEL 7'h2E
`define RST_FORMAT 2'h0
`define RST_SYNC_MODE 3'h0
`define RST_RATE 16'h0063
`define RST_SYNC_WORD 16'hA5C3
`define FMT_SYNC 2'h1
`define FMT_ASYNC 2'h3
`define CODE_SERIAL_CLK 6'h0B
`define CODE_DRIVE_EN_N 6'h2D
`define CODE_HIGH_Z 6'h2E
`define CODE_CONST_LOW 6'h2F
`define CODE_DIV_FIRST 6'h30
`define OVERSAMPLE 4'h8
`define LATENCY_BITS 8
`define PREAMBLE_BITS 6'h20
`define HEADER_BITS 6'h30
`endif

/* File: core/xosc_divider.v */
// Divided crystal clock generator for the general pins.
`timescale 1ns/1ps
module xosc_divider (
	// Clock, reset and freeze.
	input wire clk,
	input wire rst,
	input wire ce,
	// Selection.
	input wire enable,
	input wire [3:0] code,
	// Divided clock.
	output reg clk_q
);
	reg [8:0] cnt_q;
	wire [8:0] period;
	wire [8:0] cnt_d;

	// The crystal clock runs at half the reference rate, so /1.5 is a whole count of three.
	function [8:0] period_of;
		input [3:0] c;
		begin
			case (c)
				4'h0: period_of = 9'h002;
				4'h1: period_of = 9'h003;
				4'h2: period_of = 9'h004;
				4'h3: period_of = 9'h006;
				4'h4: period_of = 9'h008;
				4'h5: period_of = 9'h00C;
				4'h6: period_of = 9'h010;
				4'h7: period_of = 9'h018;
				4'h8: period_of = 9'h020;
				4'h9: period_of = 9'h030;
				4'hA: period_of = 9'h040;
				4'hB: period_of = 9'h060;
				4'hC: period_of = 9'h080;
				4'hD: period_of = 9'h0C0;
				4'hE: period_of = 9'h100;
				default: period_of = 9'h180;
			endcase
		end
	endfunction

	assign period = period_of(code);
	assign cnt_d = (cnt_q >= period - 9'h001) ? 9'h000 : cnt_q + 9'h001;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 9'h000;
			clk_q <= 1'b0;
		end else if (ce) begin
			if (!enable) begin
				cnt_q <= 9'h000;
				clk_q <= 1'b0;
			end else begin
				cnt_q <= cnt_d;
				clk_q <= (cnt_d < ((period + 9'h001) >> 1));
			end
		end
	end
endmodule

/* File: core/tx_latency_line.v */
// Fixed bit delay line between the data input and the transmitted stream.
`timescale 1ns/1ps
module tx_latency_line #(
	parameter DEPTH = 8
) (
	// Clock, reset and freeze.
	input wire clk,
	input wire rst,
	input wire ce,
	// Bit stream.
	input wire shift,
	input wire din,
	output wire dout
);
	reg [DEPTH-1:0] line_q;

	assign dout = line_q[DEPTH-1];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			line_q <= {DEPTH{1'b0}};
		end else if (ce && shift) begin
			line_q <= {line_q[DEPTH-2:0], din};
		end
	end
endmodule

/* File: core/serial_tx_port.v */
// Serial transmit data port with general pin function select and AHB-Lite registers.
`timescale 1ns/1ps
`include "serial_tx_regs.vh"
module serial_tx_port (
	// Clock, reset and freeze.
	input wire REF_CLK,
	input wire RESET,
	input wire CE,
	// AHB-Lite slave.
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output reg [31:0] HRDATA,
	output reg HREADYOUT,
	output reg HRESP,
	// General pins.
	input wire FIRST_PIN_IN,
	output reg FIRST_PIN_OUT,
	output reg FIRST_PIN_OE,
	output reg SECOND_PIN_OUT,
	output reg SECOND_PIN_OE,
	// Stream towards the modulator.
	output reg TX_ACTIVE,
	output reg TX_DATA,
	output reg TX_DATA_VALID
);
	reg [6:0] pin0_sel_q;
	reg [6:0] pin2_sel_q;
	reg [1:0] frame_format_q;
	reg manchester_q;
	reg [2:0] sync_mode_q;
	reg [15:0] rate_q;
	reg [15:0] sync_word_q;
	reg wr_pend_q;
	reg rd_pend_q;
	reg [7:0] addr_q;
	reg tx_strobe_q;
	reg idle_strobe_q;
	reg pin_meta_q;
	reg pin_sync_q;
	reg [15:0] ov_cnt_q;
	reg [2:0] sub_q;
	reg [5:0] hdr_cnt_q;
	reg sclk_q;
	reg line_shift_q;
	reg line_din_q;
	wire bus_take;
	wire tick;
	wire is_sync;
	wire is_async;
	wire first_is_input;
	wire pin0_div;
	wire pin2_div;
	wire div_clk;
	wire line_dout;
	wire header_phase;
	wire hdr_bit;
	wire [1:0] drive0;
	wire [1:0] drive2;
	wire both_div;
	wire stream_take;
	wire sclk_d;
	wire [15:0] ov_cnt_d;
	wire [2:0] sub_d;
	wire [5:0] hdr_cnt_d;
	reg [31:0] rdata;

	// Returns {output enable, level} for one pin select code.
	function [1:0] pin_drive;
		input [5:0] code;
		input inv;
		input dclk;
		input sclk;
		input en_n;
		begin
			if (code == `CODE_SERIAL_CLK)
				pin_drive = {1'b1, sclk ^ inv};
			else if (code == `CODE_DRIVE_EN_N)
				pin_drive = {1'b1, en_n ^ inv};
			else if (code == `CODE_HIGH_Z)
				pin_drive = 2'h0;
			else if (is_div_code(code))
				pin_drive = {1'b1, dclk ^ inv};
			else
				pin_drive = {1'b1, inv};
		end
	endfunction

	// True for the select codes that route a divided crystal clock.
	function is_div_code;
		input [5:0] code;
		begin
			is_div_code = (code >= `CODE_DIV_FIRST);
		end
	endfunction

	assign bus_take = HSEL && HTRANS[1] && HREADY;
	assign is_sync = (frame_format_q == `FMT_SYNC);
	assign is_async = (frame_format_q == `FMT_ASYNC);
	assign first_is_input = is_async || (is_sync && TX_ACTIVE);
	assign pin0_div = is_div_code(pin0_sel_q[5:0]);
	// The first pin owns the single divider when both ask for it.
	assign pin2_div = is_div_code(pin2_sel_q[5:0]) && !pin0_div;
	assign both_div = pin0_div && is_div_code(pin2_sel_q[5:0]);
	assign tick = (ov_cnt_q == rate_q);

	// Next values of the serial engine counters.
	assign ov_cnt_d = tick ? 16'h0000 : ov_cnt_q + 16'h0001;
	assign sub_d = sub_q + 3'h1;
	assign hdr_cnt_d = hdr_cnt_q + 6'h01;
	// Clock rises mid-bit so data set up on the falling edge has half a bit to settle.
	assign sclk_d = !header_phase && (sub_q >= 3'h3) && (sub_q != 3'h7);
	// The bit leaving the line is taken at the shift itself, which gives exactly eight bit periods.
	// Bits still held in the line when transmission stops stay there and leave first on the next transmit, so nothing leaves while idle.
	assign stream_take = line_shift_q && TX_ACTIVE;
	assign header_phase = (sync_mode_q != 3'h0) && (hdr_cnt_q < `HEADER_BITS);
	assign hdr_bit = (hdr_cnt_q < `PREAMBLE_BITS) ? ~hdr_cnt_q[0] :
		sync_word_q[4'hF - hdr_cnt_q[3:0]];
	assign drive0 = pin_drive(pin0_sel_q[5:0], pin0_sel_q[`SEL_INV_BIT], div_clk & pin0_div,
		sclk_q, ~first_is_input);
	assign drive2 = pin_drive(pin2_sel_q[5:0], pin2_sel_q[`SEL_INV_BIT], div_clk & pin2_div,
		sclk_q, ~first_is_input);

	xosc_divider u_div (
		.clk(REF_CLK),
		.rst(RESET),
		.ce(CE),
		.enable(pin0_div || pin2_div),
		.code(pin0_div ? pin0_sel_q[3:0] : pin2_sel_q[3:0]),
		.clk_q(div_clk)
	);

	tx_latency_line #(
		.DEPTH(`LATENCY_BITS)
	) u_line (
		.clk(REF_CLK),
		.rst(RESET),
		.ce(CE),
		.shift(line_shift_q),
		.din(line_din_q),
		.dout(line_dout)
	);

	always @* begin
		rdata = 32'h00000000;
		case (addr_q)
			`ADDR_PIN0_SEL: rdata[6:0] = pin0_sel_q;
			`ADDR_PIN2_SEL: rdata[6:0] = pin2_sel_q;
			`ADDR_PKT_CTRL0: rdata[1:0] = frame_format_q;
			`ADDR_MODEM_CFG2: rdata[`MANCHESTER_BIT] = manchester_q;
			`ADDR_MODEM_CFG3: rdata[2:0] = sync_mode_q;
			`ADDR_RATE: rdata[15:0] = rate_q;
			`ADDR_SYNC_WORD: rdata[15:0] = sync_word_q;
			`ADDR_STATUS: rdata[6:0] = {pin_sync_q, both_div,
				is_async, header_phase, frame_format_q, TX_ACTIVE};
			default: rdata = 32'h00000000;
		endcase
	end

	// Bus slave: writes finish with no wait, reads take one wait state.
	always @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			HRDATA <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
			pin0_sel_q <= `RST_PIN0_SEL;
			pin2_sel_q <= `RST_PIN2_SEL;
			frame_format_q <= `RST_FORMAT;
			manchester_q <= 1'b0;
			sync_mode_q <= `RST_SYNC_MODE;
			rate_q <= `RST_RATE;
			sync_word_q <= `RST_SYNC_WORD;
			tx_strobe_q <= 1'b0;
			idle_strobe_q <= 1'b0;
		end else begin
			// A strobe waits out a frozen cycle so that the engine never misses it.
			if (CE) begin
				tx_strobe_q <= 1'b0;
				idle_strobe_q <= 1'b0;
			end
			HRESP <= 1'b0;
			if (HREADYOUT) begin
				wr_pend_q <= bus_take && HWRITE;
				rd_pend_q <= bus_take && !HWRITE;
				if (bus_take) begin
					addr_q <= HADDR[7:0];
				end
				if (bus_take && !HWRITE) begin
					HREADYOUT <= 1'b0;
				end
			end else begin
				HRDATA <= rdata;
				HREADYOUT <= 1'b1;
				rd_pend_q <= 1'b0;
			end
			// Writes to the status word or to unmapped words change nothing.
			if (wr_pend_q) begin
				case (addr_q)
					`ADDR_PIN0_SEL: pin0_sel_q <= HWDATA[6:0];
					`ADDR_PIN2_SEL: pin2_sel_q <= HWDATA[6:0];
					`ADDR_PKT_CTRL0: frame_format_q <= HWDATA[1:0];
					`ADDR_MODEM_CFG2: manchester_q <= HWDATA[`MANCHESTER_BIT];
					`ADDR_MODEM_CFG3: sync_mode_q <= HWDATA[2:0];
					`ADDR_RATE: rate_q <= HWDATA[15:0];
					`ADDR_SYNC_WORD: sync_word_q <= HWDATA[15:0];
					`ADDR_COMMAND: begin
						tx_strobe_q <= HWDATA[`CMD_TX_BIT];
						idle_strobe_q <= HWDATA[`CMD_IDLE_BIT];
					end
					default: ;
				endcase
			end
		end
	end

	// Serial engine and pin drivers; everything here holds while CE is low.
	always @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			ov_cnt_q <= 16'h0000;
			sub_q <= 3'h0;
			hdr_cnt_q <= 6'h00;
			sclk_q <= 1'b0;
			line_shift_q <= 1'b0;
			line_din_q <= 1'b0;
			TX_ACTIVE <= 1'b0;
			TX_DATA <= 1'b0;
			TX_DATA_VALID <= 1'b0;
			FIRST_PIN_OUT <= 1'b0;
			FIRST_PIN_OE <= 1'b0;
			SECOND_PIN_OUT <= 1'b0;
			SECOND_PIN_OE <= 1'b0;
		end else if (CE) begin
			pin_meta_q <= FIRST_PIN_IN;
			pin_sync_q <= pin_meta_q;
			line_shift_q <= 1'b0;
			TX_DATA_VALID <= 1'b0;
			// Idle wins over a transmit strobe written in the same word.
			if (idle_strobe_q) begin
				TX_ACTIVE <= 1'b0;
			end else if (tx_strobe_q) begin
				TX_ACTIVE <= 1'b1;
			end
			if (!TX_ACTIVE || tx_strobe_q) begin
				ov_cnt_q <= 16'h0000;
				sub_q <= 3'h0;
				hdr_cnt_q <= 6'h00;
				sclk_q <= 1'b0;
			end else begin
				ov_cnt_q <= ov_cnt_d;
				if (tick) begin
					sub_q <= sub_d;
					if (is_async) begin
						TX_DATA <= pin_sync_q;
						TX_DATA_VALID <= 1'b1;
					end else if (is_sync) begin
						sclk_q <= sclk_d;
						if (sub_q == 3'h3) begin
							line_shift_q <= 1'b1;
							line_din_q <= header_phase ? hdr_bit : pin_sync_q;
							if (header_phase) begin
								hdr_cnt_q <= hdr_cnt_d;
							end
						end
					end
				end
			end
			if (stream_take) begin
				TX_DATA <= line_dout;
				TX_DATA_VALID <= 1'b1;
			end
			FIRST_PIN_OE <= drive0[1] && !first_is_input;
			FIRST_PIN_OUT <= drive0[0] && !first_is_input;
			SECOND_PIN_OE <= drive2[1];
			SECOND_PIN_OUT <= drive2[0];
		end
	end
endmodule

/* File: tb/host_src.sv */
// Host controller model feeding serial transmit data into the first pin.
`timescale 1ns/1ps
module host_src (
	// Clock and device serial clock.
	input wire clk,
	input wire sclk,
	// Mode and data, sent from bit 0 upwards.
	input wire async_en,
	input wire run,
	input wire [7:0] bit_len,
	input wire [31:0] pattern,
	// First pin.
	output reg pin
);
	reg [7:0] cnt = 8'h00;
	reg [4:0] idx = 5'h00;
	reg sclk_q = 1'b0;
	initial pin = 1'b0;
	always @(posedge clk) begin
		sclk_q <= sclk;
		if (!run) begin
			cnt <= 8'h00;
			idx <= 5'h01;
			pin <= pattern[0];
		end else if (async_en) begin
			// Exact bit periods keep the timing error far below one eighth of a bit.
			cnt <= (cnt == bit_len - 8'h01) ? 8'h00 : cnt + 8'h01;
			if (cnt == 8'h00) begin
				pin <= pattern[idx];
				idx <= idx + 5'h01;
			end
		end else if (sclk && !sclk_q) begin
			pin <= pattern[idx];
			idx <= idx + 5'h01;
		end
	end
endmodule

/* File: tb/serial_tx_port_properties.sv */
// Port checker for the serial transmit port.
`timescale 1ns/1ps
module serial_tx_port_chk (
	// Clock, reset and freeze.
	input wire REF_CLK,
	input wire RESET,
	input wire CE,
	// Bus.
	input wire HSEL,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire HREADY,
	input wire HREADYOUT,
	input wire HRESP,
	// Pin and stream.
	input wire FIRST_PIN_OUT,
	input wire FIRST_PIN_OE,
	input wire TX_ACTIVE,
	input wire TX_DATA,
	input wire TX_DATA_VALID
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	wire take = HSEL & HTRANS[1] & HREADY & HREADYOUT;
	sequence rd_wait;
		!HREADYOUT ##1 HREADYOUT;
	endsequence
	AST_READ_ONE_WAIT: assert property (take && !HWRITE |=> rd_wait) else $error("read wait wrong");
	AST_WRITE_NO_WAIT: assert property (take && HWRITE |=> HREADYOUT) else $error("write stalled");
	AST_RESP_OKAY: assert property (HRESP == 1'b0) else $error("error response");
	AST_PIN_INPUT: assert property (TX_DATA_VALID |-> !FIRST_PIN_OE) else $error("pin driven");
	AST_VALID_ACTIVE: assert property (TX_DATA_VALID |-> $past(TX_ACTIVE)) else $error("idle stream");
	AST_VALID_PULSE: assert property (TX_DATA_VALID && CE |=> !TX_DATA_VALID) else $error("long valid");
	AST_DATA_HOLD: assert property ($changed(TX_DATA) |-> TX_DATA_VALID) else $error("data moved");
	AST_FREEZE: assert property (!CE |=> $stable(FIRST_PIN_OUT) && $stable(TX_DATA_VALID)) else $error("not frozen");
endmodule
bind serial_tx_port serial_tx_port_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .CE(CE), .HSEL(HSEL),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.FIRST_PIN_OUT(FIRST_PIN_OUT), .FIRST_PIN_OE(FIRST_PIN_OE), .TX_ACTIVE(TX_ACTIVE),
	.TX_DATA(TX_DATA), .TX_DATA_VALID(TX_DATA_VALID));

/* File: tb/tb.sv */
// Self-checking bench for the serial transmit port.
`timescale 1ns/1ps
module tb;
	reg clk = 0, rst = 1, ce = 1, hsel = 0, hwrite = 0, a_en = 0, run = 0, s = 0;
	reg [1:0] htrans = 2'h0;
	reg [31:0] haddr = 32'h0, hwdata = 32'h0, pat = 32'h0, r;
	wire [31:0] hrdata;
	wire hrdy, hresp, p1o, p1e, p2o, p2e, act, txd, txv, pin;
	integer errors = 0, n_tests = 0, cyc = 0;
	integer half [0:15] = '{1, 2, 2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192};
	always #2.5 clk = ~clk;
	serial_tx_port u_dut (.REF_CLK(clk), .RESET(rst), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
		.HRESP(hresp), .FIRST_PIN_IN(pin), .FIRST_PIN_OUT(p1o), .FIRST_PIN_OE(p1e), .SECOND_PIN_OUT(p2o),
		.SECOND_PIN_OE(p2e), .TX_ACTIVE(act), .TX_DATA(txd), .TX_DATA_VALID(txv));
	host_src u_host (.clk(clk), .sclk(p2o), .async_en(a_en), .run(run), .bit_len(8'h10), .pattern(pat),
		.pin(pin));
	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input [31:0] got, input [31:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input [7:0] a, input w, input [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		r = hrdata;
	endtask
	task automatic setp(input [7:0] a, input [31:0] d);
		bus(a, 1'b1, d);
		repeat (3) @(negedge clk);
	endtask
	task automatic hi_len(output integer n);
		n = 0;
		@(negedge clk);
		while (p1o) @(negedge clk);
		while (!p1o) @(negedge clk);
		while (p1o) begin
			@(negedge clk);
			n = n + 1;
		end
	endtask
	task automatic t_reset;
		integer n, i;
		bus(8'h00, 1'b0, 32'h0);
		chk(r, 32'h3F);
		bus(8'h04, 1'b0, 32'h0);
		chk(r, 32'h2E);
		chk(32'(p2e), 32'h0);
		hi_len(n);
		chk(n, 192);
		for (i = 0; i < 16; i = i + 1) begin
			bus(8'h00, 1'b1, 32'h30 + i);
			hi_len(n);
			hi_len(n);
			chk(n, half[i]);
		end
		// Deliberately both pins ask for a divided clock; the second must stay static.
		setp(8'h04, 32'h71);
		chk(32'({p2e, p2o}), 32'h3);
	endtask
	task automatic t_pins;
		setp(8'h00, 32'h2E);
		chk(32'(p1e), 32'h0);
		setp(8'h00, 32'h2F);
		chk(32'({p1e, p1o}), 32'h2);
		setp(8'h00, 32'h6F);
		chk(32'({p1e, p1o}), 32'h3);
		setp(8'h04, 32'h2D);
		chk(32'({p2e, p2o}), 32'h3);
		setp(8'h08, 32'h3);
		chk(32'({p2o, p1e}), 32'h0);
		bus(8'h20, 1'b0, 32'h0);
		chk(r & 32'h16, 32'h16);
	endtask
	task automatic t_async;
		integer i, n;
		reg [3:0] h;
		h = 4'h0;
		n = 0;
		@(posedge clk);
		pat <= 32'h5A3C_0F35;
		a_en <= 1'b1;
		run <= 1'b1;
		bus(8'h14, 1'b1, 32'h1);
		bus(8'h1C, 1'b1, 32'h1);
		repeat (4) @(negedge clk);
		for (i = 0; i < 160; i = i + 1) begin
			@(negedge clk);
			if (txv)
				n = n + 1;
			if (txv && h[1] == h[2] && h[2] == h[3])
				chk(32'(txd), 32'(h[2]));
			h = {h[2:0], pin};
		end
		chk(n, 80);
		@(posedge clk);
		ce <= 1'b0;
		repeat (20) @(posedge clk);
		ce <= 1'b1;
		bus(8'h1C, 1'b1, 32'h3);
		repeat (4) @(negedge clk);
		chk(32'(act), 32'h0);
	endtask
	task automatic t_sync;
		integer t0, t1, i, rp, rc;
		setp(8'h08, 32'h1);
		setp(8'h04, 32'h0B);
		bus(8'h0C, 1'b1, 32'h0);
		bus(8'h10, 1'b1, 32'h0);
		@(posedge clk);
		a_en <= 1'b0;
		run <= 1'b0;
		pat <= 32'h10;
		@(posedge clk);
		run <= 1'b1;
		bus(8'h1C, 1'b1, 32'h1);
		t0 = 0;
		t1 = 0;
		rp = 0;
		rc = 0;
		for (i = 1; i < 600 && t1 == 0; i = i + 1) begin
			@(negedge clk);
			if (p2o && !s) begin
				rp = rc;
				rc = i;
				if (pin && t0 == 0)
					t0 = i;
			end
			if (txv && txd && t0 != 0)
				t1 = i;
			s = p2o;
		end
		chk(rc - rp, 16);
		chk((t1 - t0 + 8) / 16, 8);
		chk(32'(p1e), 32'h0);
	endtask
	task automatic t_head;
		integer i, f, k;
		reg [71:0] q;
		reg [47:0] w;
		bus(8'h1C, 1'b1, 32'h2);
		@(posedge clk);
		pat <= 32'h0;
		bus(8'h10, 1'b1, 32'h1);
		bus(8'h1C, 1'b1, 32'h1);
		k = 0;
		for (i = 0; i < 1400 && k < 72; i = i + 1) begin
			@(negedge clk);
			if (txv) begin
				q[k] = txd;
				k = k + 1;
			end
		end
		f = 0;
		while (f < 16 && q[f] !== 1'b1)
			f = f + 1;
		for (i = 0; i < 48; i = i + 1)
			w[47 - i] = q[f + i];
		chk(w[47:16], 32'hAAAA_AAAA);
		chk(32'(w[15:0]), 32'hA5C3);
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			final_report;
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_pins;
		t_async;
		t_sync;
		t_head;
		final_report;
	end
endmodule
